// file: verilog/bdfm_pkg.sv
// Purpose: Shared constants and types for the burst drive fault monitor
// Assumes: 50 MHz core clock; control pins arrive asynchronously
// Notes:   Field widths and the timeout unit are plain defaults

package bdfm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;               // Core clock period
    localparam int TO_UNIT_NS    = 1000;             // One timeout field step
    localparam int TO_UNIT_CYC   = (TO_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int PULSE_W  = 6;                     // Programmed pulse count
    localparam int TO_FLD_W = 3;                     // Toggle timeout field
    localparam int TO_CNT_W = 10;                    // Timeout / blank counter

    // Timeout field value that clears the stuck flag and disables the check
    localparam logic [TO_FLD_W-1:0] TO_FLD_OFF = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [PULSE_W-1:0]  CNT_RST = 6'h00;
    localparam logic [TO_CNT_W-1:0] TO_RST  = 10'h000;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        BDFM_MODE_SPI    = 2'h0,                     // Trigger from serial bit
        BDFM_MODE_PIN_A  = 2'h1,                     // Enable from control pin a
        BDFM_MODE_DUAL   = 2'h2,                     // Pin a drives both legs; either pin arms
        BDFM_MODE_SINGLE = 2'h3                      // Pin b enables and starts
    } bdfm_mode_t;

    typedef struct packed {
        bdfm_mode_t           mode;                  // Control mode
        logic [PULSE_W-1:0]   pulse_num;             // Programmed pulse count
        logic [TO_FLD_W-1:0]  toggle_timeout_period; // Toggle timeout field
        logic                 single_leg_drive_select; // Half-bridge drive
    } bdfm_cfg_t;

endpackage

// file: verilog/bdfm_pin_sync.sv
// Purpose: Two-stage synchroniser with edge detection for one control pin
// Assumes: Pin is asynchronous to clk
// Notes:   Edges are taken only from the second and third stages

`timescale 1ns/1ns

module bdfm_pin_sync
    import bdfm_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clk_en,
    // Pin and results
    input  wire logic pin,
    output logic      level,
    output logic      fall,
    output logic      rise
);

    logic [2:0] sh_q;   // Stage 0 feeds only stage 1
    logic [2:0] sh_d;   // Next shift value

    ////////////////////////////////////////////////////////////////////////////
    // Next shift value; frozen while the enable is low
    always_comb begin
        sh_d = clk_en ? {sh_q[1:0], pin} : sh_q;
    end

    // Register the chain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_q <= 3'h7;   // Idle high, so no false edge at release
        end else begin
            sh_q <= sh_d;
        end
    end

    assign level = sh_q[1];
    assign fall  = sh_q[2] & ~sh_q[1];
    assign rise  = ~sh_q[2] & sh_q[1];

endmodule

// file: verilog/bdfm_monitor.sv
// Purpose: Burst sequencing with pulse-count and stuck-drive fault monitoring
// Assumes: Control pins are asynchronous; config and standby are core-clock signals
// Notes:   Drive outputs are released low outside a burst

`timescale 1ns/1ns

module bdfm_monitor
    import bdfm_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      clk_en,
    // Control pins from the controller
    input  wire logic      ctrl_pin_a,
    input  wire logic      ctrl_pin_b,
    // Configuration and power state
    input  wire bdfm_cfg_t cfg,
    input  wire logic      spi_trigger,
    input  wire logic      toggle_timeout_wr,
    input  wire logic      standby_or_sleep,
    // Drive and status
    output logic           drive_out_a,
    output logic           drive_out_b,
    output logic           burst_active,
    output logic           pulse_count_fault,
    output logic           stuck_drive_fault
);

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BURST, ST_BLANK} bdfm_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Timeout length in cycles for a field value
    function automatic logic [TO_CNT_W-1:0] to_limit(input logic [TO_FLD_W-1:0] fld);
        logic [TO_CNT_W-1:0] steps;
        steps    = TO_CNT_W'(fld) + TO_CNT_W'(1);
        to_limit = TO_CNT_W'(steps * TO_CNT_W'(TO_UNIT_CYC));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic a_lvl, a_fall, a_rise;   // Pin a level and edges
    logic b_lvl, b_fall, b_rise;   // Pin b level and edges

    bdfm_pin_sync u_sync_a (
        .clk    (clk),
        .rst    (rst),
        .clk_en (clk_en),
        .pin    (ctrl_pin_a),
        .level  (a_lvl),
        .fall   (a_fall),
        .rise   (a_rise)
    );

    bdfm_pin_sync u_sync_b (
        .clk    (clk),
        .rst    (rst),
        .clk_en (clk_en),
        .pin    (ctrl_pin_b),
        .level  (b_lvl),
        .fall   (b_fall),
        .rise   (b_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State
    bdfm_state_t         st_q, st_d;       // Burst sequencer
    logic [PULSE_W-1:0]  cnt_q, cnt_d;     // Pulses since start
    logic [TO_CNT_W-1:0] to_q, to_d;       // Toggle timer or blank timer
    logic                trig_q, trig_d;   // Last serial trigger, for rising detect
    logic                pcf_q, pcf_d;     // Pulse count fault
    logic                sdf_q, sdf_d;     // Stuck drive fault
    logic                da_q, da_d;       // Drive leg a
    logic                db_q, db_d;       // Drive leg b
    logic                ba_q, ba_d;       // Burst flag, registered so the output is a flop

    // Decoded helpers
    logic                counting;         // Modes that count pulses
    logic                tog;              // Edge relevant to the toggle timer
    logic                count_done;       // Programmed count reached
    logic                short_end;        // Ending before the count was sent
    logic                ext_end;          // Controller asked for end of burst
    logic                timeout;          // Toggle timer expired
    logic                start;            // Start of burst this cycle
    logic [TO_CNT_W-1:0] lim;              // Current timer limit

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for sequencer, counters, flags and drive
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        to_d   = to_q;
        trig_d = spi_trigger;
        pcf_d  = pcf_q;
        sdf_d  = sdf_q;
        start  = 1'b0;
        lim    = to_limit(cfg.toggle_timeout_period);
        counting = (cfg.mode != BDFM_MODE_DUAL);
        // Dual mode watches both pins, the others only the clock on pin b
        tog = counting ? (b_fall | b_rise) : (a_fall | a_rise | b_fall | b_rise);
        // Zero count never completes in modes 0 and 1; mode 3 has no continuous run
        count_done = counting && (cnt_q == cfg.pulse_num)
                     && !(cfg.pulse_num == CNT_RST && cfg.mode != BDFM_MODE_SINGLE);
        short_end  = counting && (cfg.pulse_num != CNT_RST) && (cnt_q < cfg.pulse_num);
        ext_end    = (cfg.mode == BDFM_MODE_SPI && !spi_trigger)
                     || (cfg.mode == BDFM_MODE_PIN_A && a_lvl)
                     || (cfg.mode == BDFM_MODE_DUAL && a_lvl && b_lvl);
        timeout    = (cfg.toggle_timeout_period != TO_FLD_OFF) && (to_q >= lim);

        // Clears first, so a set further down wins in the same cycle
        if (toggle_timeout_wr && cfg.toggle_timeout_period == TO_FLD_OFF) begin
            sdf_d = 1'b0;
        end
        if (standby_or_sleep) begin
            sdf_d = 1'b0;
            pcf_d = 1'b0;
        end

        case (st_q)
            ST_IDLE: begin
                to_d  = TO_RST;
                cnt_d = CNT_RST;
                case (cfg.mode)
                    // Serial trigger must go low then high again
                    BDFM_MODE_SPI: begin
                        if (spi_trigger && !trig_q) begin
                            st_d = ST_ARMED;
                        end
                    end
                    BDFM_MODE_PIN_A: begin
                        if (a_fall) begin
                            st_d = ST_ARMED;
                        end
                    end
                    BDFM_MODE_DUAL: begin
                        if (a_fall || b_fall) begin
                            st_d = ST_ARMED;
                        end
                    end
                    default: begin
                        start = b_fall;
                    end
                endcase
            end
            ST_ARMED: begin
                // Enabled; nothing counted until the start edge
                if (ext_end && cfg.mode != BDFM_MODE_DUAL) begin
                    st_d = ST_IDLE;
                end else if (cfg.mode == BDFM_MODE_DUAL) begin
                    start = a_fall;
                end else begin
                    start = b_fall;
                end
            end
            ST_BURST: begin
                to_d = tog ? TO_RST : to_q + TO_CNT_W'(1);
                if (b_fall && counting && !count_done) begin
                    cnt_d = cnt_q + PULSE_W'(1);
                end
                if (count_done || timeout || ext_end) begin
                    st_d = (cfg.mode == BDFM_MODE_SINGLE) ? ST_BLANK : ST_IDLE;
                    to_d = TO_RST;
                    if (!count_done && timeout) begin
                        sdf_d = 1'b1;
                    end
                    if (!count_done && short_end) begin
                        pcf_d = 1'b1;
                    end
                end
            end
            ST_BLANK: begin
                // Pin b edges ignored until the blank interval runs out
                to_d = to_q + TO_CNT_W'(1);
                if (to_q >= lim) begin
                    st_d = ST_IDLE;
                    to_d = TO_RST;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase

        if (start) begin
            st_d  = ST_BURST;
            cnt_d = CNT_RST;
            to_d  = TO_RST;
            pcf_d = 1'b0;
            sdf_d = 1'b0;
        end
        // Standby leaves any burst at once
        if (standby_or_sleep) begin
            st_d = ST_IDLE;
        end

        // Drivers follow the pins only inside a burst; released otherwise
        if (st_d == ST_BURST) begin
            da_d = counting ? b_lvl : ~a_lvl;
            db_d = cfg.single_leg_drive_select ? 1'b0 : (counting ? ~b_lvl : ~b_lvl);
            if (!counting && !cfg.single_leg_drive_select) begin
                db_d = ~da_d;
            end
        end else begin
            da_d = 1'b0;
            db_d = 1'b0;
        end

        // A low enable freezes everything
        if (!clk_en) begin
            st_d   = st_q;
            cnt_d  = cnt_q;
            to_d   = to_q;
            trig_d = trig_q;
            pcf_d  = pcf_q;
            sdf_d  = sdf_q;
            da_d   = da_q;
            db_d   = db_q;
        end
        // Follows the next state, so it matches the state flop cycle for cycle
        ba_d = (st_d == ST_BURST);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; flags power up clear and hold until a clearing event
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q   <= ST_IDLE;
            cnt_q  <= CNT_RST;
            to_q   <= TO_RST;
            trig_q <= 1'b0;
            pcf_q  <= 1'b0;
            sdf_q  <= 1'b0;
            da_q   <= 1'b0;
            db_q   <= 1'b0;
            ba_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            to_q   <= to_d;
            trig_q <= trig_d;
            pcf_q  <= pcf_d;
            sdf_q  <= sdf_d;
            da_q   <= da_d;
            db_q   <= db_d;
            ba_q   <= ba_d;
        end
    end

    assign drive_out_a       = da_q;
    assign drive_out_b       = db_q;
    assign burst_active      = ba_q;
    assign pulse_count_fault = pcf_q;
    assign stuck_drive_fault = sdf_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_short_count: assert property (clk_en && st_q == ST_BURST && ext_end && !count_done && !timeout
        && short_end && !standby_or_sleep |=> pulse_count_fault)
        else $error("short burst did not set count fault");
    chk_timer_restart: assert property (clk_en && st_q == ST_BURST && tog && !count_done && !timeout
        && !ext_end && !standby_or_sleep |=> to_q == TO_RST)
        else $error("toggle timer not restarted");
    chk_timeout_end: assert property (clk_en && st_q == ST_BURST && timeout && !count_done
        && !standby_or_sleep |=> stuck_drive_fault && !burst_active ##1 !drive_out_a && !drive_out_b)
        else $error("timeout did not end burst");
    chk_stuck_count: assert property ($rose(stuck_drive_fault) && counting && cnt_q < cfg.pulse_num
        |-> pulse_count_fault)
        else $error("stuck end missed count fault");
    // A fault raised in the same cycle as standby wins over the clear, so bursts are left out
    chk_stuck_clear: assert property (clk_en && standby_or_sleep && st_q != ST_BURST
        |=> !stuck_drive_fault && !pulse_count_fault)
        else $error("standby left a fault set");
    chk_count_hold: assert property (clk_en && toggle_timeout_wr && pulse_count_fault && !start
        && !standby_or_sleep |=> pulse_count_fault)
        else $error("timeout write cleared count fault");
    chk_flag_hold: assert property (!clk_en |=> $stable(pulse_count_fault) && $stable(stuck_drive_fault))
        else $error("fault changed while frozen");
    chk_antiphase: assert property (burst_active && $past(burst_active) && !cfg.single_leg_drive_select
        && $stable(cfg.single_leg_drive_select) |-> drive_out_a != drive_out_b)
        else $error("legs not in antiphase");
    chk_single_leg: assert property ($past(cfg.single_leg_drive_select) && $past(clk_en) |-> !drive_out_b)
        else $error("leg b driven in half-bridge mode");
    chk_start_edge: assert property (clk_en && start && !standby_or_sleep |=> burst_active && cnt_q == CNT_RST)
        else $error("start edge did not open burst");
    chk_blank_hold: assert property (clk_en && st_q == ST_BLANK && to_q < lim && !standby_or_sleep
        |=> st_q == ST_BLANK && !burst_active)
        else $error("burst began during blank interval");

endmodule

// file: test/bdfm_mcu_model.sv
// Purpose: Controller model driving the two control pins of the monitor
// Assumes: Pins rest high; burst clock period 160 ns (four core cycles per half)
// Notes:   Tasks are entered on the falling edge of clk and drive there only

`timescale 1ns/1ns

module bdfm_mcu_model (
    // Clock
    input  wire logic clk,
    // Control pins
    output logic      ctrl_pin_a,
    output logic      ctrl_pin_b
);

    ////////////////////////////////////////////////////////////////////////////
    localparam int HALF_CYC = 4;        // Half burst clock period in core cycles

    // Pins rest high so that the first fall is a clean start of burst
    initial begin
        ctrl_pin_a = 1'b1;
        ctrl_pin_b = 1'b1;
    end

    // Whole core cycles on the drive edge
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Burst clock: n falls on pin b, each followed by a rise
    task automatic b_pulses(input int n);
        repeat (n) begin
            ctrl_pin_b = 1'b0;
            wait_cyc(HALF_CYC);
            ctrl_pin_b = 1'b1;
            wait_cyc(HALF_CYC);
        end
    endtask

    // Lost clock: pin b stays low for n cycles, then goes back high
    task automatic b_stuck(input int n);
        ctrl_pin_b = 1'b0;
        wait_cyc(n);
        ctrl_pin_b = 1'b1;
    endtask

    // Pin a level; a fall arms mode 1, a rise ends its burst
    task automatic set_a(input logic v);
        ctrl_pin_a = v;
        wait_cyc(HALF_CYC);
    endtask

endmodule

// file: test/testbench.sv
// Purpose: Self-checking bench for the burst drive fault monitor
// Assumes: Pin edges reach the monitor about three cycles after they move
// Notes:   Timeout limit is (field+1)*50 cycles; blank-out uses the same limit

`timescale 1ns/1ns

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH %0t ns value differs from expected", $time); end end

module testbench;
    import bdfm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic      clk = 1'b0;               // Core clock
    logic      rst = 1'b1;               // Async reset
    logic      clk_en = 1'b1;            // Running except while t_dual freezes it
    logic      spi_trigger = 1'b0;       // Serial trigger bit
    logic      toggle_timeout_wr = 1'b0; // Field write pulse
    logic      standby_or_sleep = 1'b0;  // Power state
    logic      ctrl_pin_a;               // From controller model
    logic      ctrl_pin_b;               // From controller model
    logic      drive_out_a;              // Leg a
    logic      drive_out_b;              // Leg b
    logic      burst_active;             // In burst
    logic      pulse_count_fault;        // Count flag
    logic      stuck_drive_fault;        // Stuck flag
    bdfm_cfg_t cfg = '{BDFM_MODE_SINGLE, 6'h02, 3'h2, 1'b0};
    int        error_cnt = 0;            // Mismatches
    int        n_checks = 0;             // Comparisons
    int        phase_chk = 0;            // 1 antiphase, 2 single leg

    always #10 clk = ~clk;

    bdfm_mcu_model mcu_i (.clk(clk), .ctrl_pin_a(ctrl_pin_a), .ctrl_pin_b(ctrl_pin_b));

    bdfm_monitor bdfm_monitor_i (.clk(clk), .rst(rst), .clk_en(clk_en), .ctrl_pin_a(ctrl_pin_a),
        .ctrl_pin_b(ctrl_pin_b), .cfg(cfg), .spi_trigger(spi_trigger),
        .toggle_timeout_wr(toggle_timeout_wr), .standby_or_sleep(standby_or_sleep),
        .drive_out_a(drive_out_a), .drive_out_b(drive_out_b), .burst_active(burst_active),
        .pulse_count_fault(pulse_count_fault), .stuck_drive_fault(stuck_drive_fault));

    ////////////////////////////////////////////////////////////////////////////
    // Leg relation watched every cycle of a burst while phase_chk is nonzero
    always @(negedge clk) begin
        if (phase_chk != 0 && burst_active === 1'b1) begin
            if (phase_chk == 1) `CHK(drive_out_b, ~drive_out_a)
            else `CHK(drive_out_b, 1'b0)
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One-cycle write of the timeout field
    task automatic wr_field(input logic [2:0] v);
        cfg.toggle_timeout_period = v;
        toggle_timeout_wr = 1'b1;
        cyc(1);
        toggle_timeout_wr = 1'b0;
        cyc(2);
    endtask

    task automatic t_reset;
        cyc(5);
        rst = 1'b0;
        cyc(4);
        `CHK(pulse_count_fault, 1'b0)
        `CHK(stuck_drive_fault, 1'b0)
    endtask

    // Mode 3 full count, then blank-out against an early restart
    task automatic t_mode3;
        phase_chk = 1;
        mcu_i.b_pulses(1);
        `CHK(burst_active, 1'b1)
        mcu_i.b_pulses(2);
        cyc(2);
        `CHK(burst_active, 1'b0)
        `CHK(pulse_count_fault, 1'b0)
        mcu_i.b_pulses(1);
        `CHK(burst_active, 1'b0)
        cyc(150);
        mcu_i.b_pulses(1);
        `CHK(burst_active, 1'b1)
        mcu_i.b_pulses(2);
        cyc(160);
        phase_chk = 0;
    endtask

    // Mode 1 ended early by pin a; flag must persist
    task automatic t_short;
        cfg.mode = BDFM_MODE_PIN_A;
        cfg.pulse_num = 6'h05;
        mcu_i.set_a(1'b0);
        mcu_i.b_pulses(2);
        mcu_i.set_a(1'b1);
        `CHK(burst_active, 1'b0)
        `CHK(pulse_count_fault, 1'b1)
        `CHK(stuck_drive_fault, 1'b0)
        cyc(100);
        `CHK(pulse_count_fault, 1'b1)
        // Mid-run reset with the count flag set must clear it
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(3);
        `CHK(pulse_count_fault, 1'b0)
    endtask

    // Mode 0 continuous run; a zero count leaves the count flag clear at its end
    task automatic t_cont;
        cfg.mode = BDFM_MODE_SPI;
        cfg.pulse_num = 6'h00;
        spi_trigger = 1'b1;
        cyc(2);
        mcu_i.b_pulses(1);
        `CHK(pulse_count_fault, 1'b0)
        mcu_i.b_pulses(12);
        `CHK(burst_active, 1'b1)
        spi_trigger = 1'b0;
        cyc(4);
        `CHK(burst_active, 1'b0)
        `CHK(pulse_count_fault, 1'b0)
    endtask

    // Lost clock with a 50 cycle limit, then the clearing events
    task automatic t_stuck;
        cfg.pulse_num = 6'h05;
        wr_field(3'h0);
        spi_trigger = 1'b1;
        cyc(2);
        mcu_i.b_stuck(40);
        `CHK(burst_active, 1'b1)
        cyc(45);
        `CHK(burst_active, 1'b1)
        cyc(15);
        `CHK(burst_active, 1'b0)
        `CHK(drive_out_a | drive_out_b, 1'b0)
        `CHK(stuck_drive_fault, 1'b1)
        `CHK(pulse_count_fault, 1'b1)
        spi_trigger = 1'b0;
        wr_field(3'h3);
        `CHK(stuck_drive_fault, 1'b1)
        wr_field(3'h7);
        `CHK(stuck_drive_fault, 1'b0)
        `CHK(pulse_count_fault, 1'b1)
        standby_or_sleep = 1'b1;
        cyc(2);
        standby_or_sleep = 1'b0;
        `CHK(pulse_count_fault, 1'b0)
    endtask

    // Mode 2: arm on pin b, start on pin a, lost clock, frozen clear, both-high end
    task automatic t_dual;
        cfg.mode = BDFM_MODE_DUAL;
        cfg.pulse_num = 6'h38;          // Ignored in this mode
        wr_field(3'h0);
        phase_chk = 1;
        mcu_i.b_stuck(4);
        mcu_i.set_a(1'b0);
        `CHK(burst_active, 1'b1)
        mcu_i.b_stuck(4);
        cyc(40);
        `CHK(burst_active, 1'b1)
        cyc(15);
        `CHK(burst_active, 1'b0)
        `CHK(drive_out_a | drive_out_b, 1'b0)
        `CHK(stuck_drive_fault, 1'b1)
        `CHK(pulse_count_fault, 1'b0)
        mcu_i.set_a(1'b1);
        // Standby while frozen must not reach the flags
        clk_en = 1'b0;
        standby_or_sleep = 1'b1;
        cyc(3);
        standby_or_sleep = 1'b0;
        cyc(1);
        clk_en = 1'b1;
        `CHK(stuck_drive_fault, 1'b1)
        mcu_i.b_stuck(4);
        mcu_i.set_a(1'b0);
        `CHK(stuck_drive_fault, 1'b0)
        mcu_i.set_a(1'b1);
        `CHK(burst_active, 1'b0)
        `CHK(drive_out_a | drive_out_b, 1'b0)
        phase_chk = 0;
    endtask

    // Single leg drive in mode 3
    task automatic t_half;
        cfg.mode = BDFM_MODE_SINGLE;
        cfg.pulse_num = 6'h02;
        cfg.single_leg_drive_select = 1'b1;
        wr_field(3'h2);
        phase_chk = 2;
        mcu_i.b_pulses(3);
        cyc(2);
        `CHK(burst_active, 1'b0)
        phase_chk = 0;
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog well beyond the fewer than a thousand cycles of the run
    initial begin
        #400000;
        error_cnt++;
        $display("MISMATCH %0t ns watchdog expired", $time);
        end_of_test();
    end

    initial begin
        t_reset();
        t_mode3();
        t_short();
        t_cont();
        t_stuck();
        t_dual();
        t_half();
        end_of_test();
    end

endmodule
